// ---- agc_loop_sva.sv ----
`timescale 1ns/10ps
`include "gain_loop_map.vh"
module agc_loop_sva #(
	parameter COUNT_W = 4
) (
	// clock, reset and register port
	input wire               core_clk,
	input wire               rst,
	input wire [7:0]         reg_addr,
	input wire [7:0]         reg_wdata,
	input wire               reg_write,
	// data path and events
	input wire               last_dec_valid,
	input wire [23:0]        last_dec_i,
	input wire               gain_out_valid,
	input wire [15:0]        gain_out_i,
	input wire               adc_overload,
	input wire               adc_reset_event,
	input wire               frame_sample_strobe,
	// controls and frame fields
	input wire [7:0]         gain_dac_code,
	input wire               dac_fast_mode,
	input wire               mixer_atten_enable,
	input wire [5:0]         signal_strength_value,
	input wire [7:0]         attenuation_report,
	input wire [COUNT_W-1:0] overload_count,
	input wire [COUNT_W-1:0] reset_count
);
	reg  [15:0]        gain_sh;
	reg  [7:0]         cfg_sh;
	reg  [1:0]         known;
	reg  [2:0]         settle;
	reg  [5:0]         tick;
	reg  [COUNT_W-1:0] ov_acc;
	reg  [COUNT_W-1:0] rs_acc;
	wire               manual = (cfg_sh[2:0] == 3'h0);
	wire               calm   = (settle == 3'h7);
	wire               wr_hi  = reg_write && (reg_addr == `ADDR_GAIN_HIGH);
	wire               wr_lo  = reg_write && (reg_addr == `ADDR_GAIN_LOW);
	wire [COUNT_W-1:0] full   = {COUNT_W{1'b1}};
	wire [COUNT_W-1:0] ov_inc = {{(COUNT_W-1){1'b0}}, adc_overload && ov_acc != full};
	wire [COUNT_W-1:0] rs_inc = {{(COUNT_W-1){1'b0}}, adc_reset_event && rs_acc != full};

	// the gain shadow is trusted only in manual mode, the loop rewrites it otherwise
	always @(posedge core_clk) begin
		if (rst) begin
			{gain_sh, cfg_sh, known, settle, tick} <= {16'h0000, 8'h00, 2'b11, 3'h0, 6'h00};
			ov_acc <= {COUNT_W{1'b0}};
			rs_acc <= {COUNT_W{1'b0}};
		end else begin
			tick   <= (tick == 6'h3b) ? 6'h00 : tick + 6'h01;
			settle <= reg_write ? 3'h0 : (calm ? settle : settle + 3'h1);
			if (wr_hi)
				gain_sh[15:8] <= reg_wdata;
			if (wr_lo)
				gain_sh[7:0] <= reg_wdata;
			if (reg_write && reg_addr == `ADDR_LOOP_CONFIG)
				cfg_sh <= reg_wdata;
			known  <= manual ? (known | {wr_hi, wr_lo}) : 2'b00;
			ov_acc <= frame_sample_strobe ? {{(COUNT_W-1){1'b0}}, adc_overload} : ov_acc + ov_inc;
			rs_acc <= frame_sample_strobe ? {{(COUNT_W-1){1'b0}}, adc_reset_event} : rs_acc + rs_inc;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_unity_in;
		last_dec_valid && calm && (!cfg_sh[7] || (manual && known == 2'b11 && gain_sh[14]));
	endsequence
	sequence s_unity_out;
		gain_out_valid && gain_out_i == $past(last_dec_i[23:8]);
	endsequence

	AST_REPORT_MATCH: assert property (calm && manual && known == 2'b11 |-> attenuation_report == gain_sh[15:8])
		else $error("attenuation report differs from gain register");
	AST_MIXER_BIT: assert property (calm && manual && known == 2'b11 |-> mixer_atten_enable == gain_sh[15])
		else $error("mixer attenuation differs from gain bit 15");
	AST_DAC_MANUAL: assert property (calm && manual && known == 2'b11 && !cfg_sh[7] |-> gain_dac_code == gain_sh[13:6])
		else $error("dac code differs from gain bits 13 to 6");
	AST_FAST_MODE: assert property (calm |-> dac_fast_mode == (cfg_sh[3] && !manual))
		else $error("fast mode output wrong");
	AST_STRENGTH_TICK: assert property ($changed(signal_strength_value) |-> $past(tick) == 6'h3b)
		else $error("strength changed off the loop tick");
	AST_MANUAL_FROZEN: assert property (manual && calm |-> $stable(attenuation_report))
		else $error("gain moved in manual mode");
	AST_LOOP_TICK: assert property ($changed(attenuation_report) && calm |-> $past(tick, 2) == 6'h3b)
		else $error("loop gain changed off the loop tick");
	AST_COUNT_LATCH: assert property (frame_sample_strobe |=> overload_count == $past(ov_acc) && reset_count == $past(rs_acc))
		else $error("event counts wrong at frame strobe");
	AST_UNITY_PASS: assert property (s_unity_in |=> s_unity_out)
		else $error("unity gain data path wrong");
endmodule // agc_loop_sva

bind automatic_gain_control_loop agc_loop_sva #(.COUNT_W(COUNT_W)) u_agc_loop_sva (
	.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .last_dec_valid(last_dec_valid), .last_dec_i(last_dec_i),
	.gain_out_valid(gain_out_valid), .gain_out_i(gain_out_i), .adc_overload(adc_overload),
	.adc_reset_event(adc_reset_event), .frame_sample_strobe(frame_sample_strobe),
	.gain_dac_code(gain_dac_code), .dac_fast_mode(dac_fast_mode),
	.mixer_atten_enable(mixer_atten_enable), .signal_strength_value(signal_strength_value),
	.attenuation_report(attenuation_report), .overload_count(overload_count),
	.reset_count(reset_count)
);

// ---- automatic_gain_control_loop.v ----
`timescale 1ns/10ps
`include "gain_loop_map.vh"

// Summary of operation
// - digital gain scales data only while its enable bit is one.
// - reference field zero means manual mode, gain from the gain register.
// - gain register top bit enables fixed 16 dB mixer attenuation.
// - low 15 bits span -12..+12 dB with digital gain, 14 bits otherwise.
// - analog attenuation leaves as an 8-bit control DAC code.
// - fast acquisition bit lowers DAC output resistance in automatic mode.
// - 6-bit strength value, code 60 is full scale.
// - strength value refreshes every 60 clocks.
// - automatic loop updates gain every 60 clocks toward the reference.
// - reference codes 1..5 target 3,6,9,12,15 dB below clip.
// - reference code zero disables automatic adjustment.
// - with digital gain on, loop maximises digital gain under reference.
// - level estimate is |I|+|Q| at first decimator and digital gain output.
// - count overloads and ADC resets per output sample; report gain MSBs.
// - attenuation report equals top 8 bits of the gain register.
// - without digital gain, loop uses only the first decimator estimate.
// - level above reference raises attenuation by attack-scaled error.
// - level below reference lowers attenuation by attack minus decay.
// - 12 dB analog span plus 12 dB digital gain span.
// - attack and decay are 4-bit, each step a factor of root two.
// - digital gain is 1..4; results pushed past the 24-bit range clip.
module automatic_gain_control_loop #(
	parameter COUNT_W = 4
) (
	// clock and reset
	input  wire               core_clk,
	input  wire               rst,
	// register port
	input  wire [7:0]         reg_addr,
	input  wire [7:0]         reg_wdata,
	input  wire               reg_write,
	input  wire               reg_read,
	output reg  [7:0]         reg_rdata,
	// first decimator samples
	input  wire               first_dec_valid,
	input  wire [15:0]        first_dec_i,
	input  wire [15:0]        first_dec_q,
	// last decimator samples
	input  wire               last_dec_valid,
	input  wire [23:0]        last_dec_i,
	input  wire [23:0]        last_dec_q,
	// converter events and output sample strobe
	input  wire               adc_overload,
	input  wire               adc_reset_event,
	input  wire               frame_sample_strobe,
	// scaled output data
	output wire               gain_out_valid,
	output wire [15:0]        gain_out_i,
	output wire [15:0]        gain_out_q,
	// analog controls
	output reg  [7:0]         gain_dac_code,
	output reg                dac_fast_mode,
	output reg                mixer_atten_enable,
	// serial frame fields
	output reg  [5:0]         signal_strength_value,
	output reg  [7:0]         attenuation_report,
	output reg  [COUNT_W-1:0] overload_count,
	output reg  [COUNT_W-1:0] reset_count
);

	reg  [15:0]        gain_setting_reg;
	reg  [7:0]         loop_rate_reg;
	reg  [7:0]         loop_config_reg;
	reg  [5:0]         tick_count_reg;
	reg  [16:0]        first_level_reg;
	reg  [16:0]        final_level_reg;
	reg                reset_seen_reg;
	reg  [COUNT_W-1:0] overload_run_reg;
	reg  [COUNT_W-1:0] reset_run_reg;

	wire        tick;
	wire        digital_gain_enable;
	wire [2:0]  reference_level_select;
	wire        auto_mode;
	wire [3:0]  attack_rate;
	wire [3:0]  decay_ratio;
	wire [2:0]  reset_weight;
	wire [15:0] atten_code;
	wire [15:0] atten_max;

	reg  [7:0]  ref_frac;
	reg  [16:0] ref_level;
	reg  [16:0] est_level;
	reg  [16:0] err_mag;
	reg  [4:0]  k_index;
	reg  [17:0] err_root;
	reg  [32:0] err_shift;
	reg  [15:0] step;
	reg  [15:0] reset_add;
	reg  [17:0] up_sum;
	reg  [15:0] gain_next;
	reg  [13:0] analog_code;
	reg  [13:0] digital_amount;
	reg  [15:0] digital_factor;
	reg  [24:0] strength_prod;

	function [16:0] abs_sum;
		input [15:0] a;
		input [15:0] b;
		reg   [15:0] abs_a;
		reg   [15:0] abs_b;
		begin
			abs_a   = a[15] ? (~a + 16'h0001) : a;
			abs_b   = b[15] ? (~b + 16'h0001) : b;
			abs_sum = {1'b0, abs_a} + {1'b0, abs_b};
		end
	endfunction

	assign digital_gain_enable    = loop_config_reg[`BIT_DIG_ENABLE];
	assign reference_level_select = loop_config_reg[`FIELD_REF_LEVEL];
	assign reset_weight           = loop_config_reg[`FIELD_RESET_WEIGHT];
	assign attack_rate            = loop_rate_reg[`FIELD_ATTACK];
	assign decay_ratio            = loop_rate_reg[`FIELD_DECAY];
	assign auto_mode              = (reference_level_select != `REF_OFF);
	assign atten_code             = {1'b0, gain_setting_reg[`FIELD_GAIN_CODE]};
	assign atten_max              = digital_gain_enable ? `ATTEN_MAX_DIG : `ATTEN_MAX_ANA;
	assign tick                   = (tick_count_reg == `TICK_LAST);

	// loop sample clock at one sixtieth of the modulator clock
	always @(posedge core_clk) begin
		if (rst)
			tick_count_reg <= 6'h00;
		else if (tick)
			tick_count_reg <= 6'h00;
		else
			tick_count_reg <= tick_count_reg + 6'h01;
	end

	// level estimates; the latest sample in each loop period is what counts
	always @(posedge core_clk) begin
		if (rst) begin
			first_level_reg <= 17'h0_0000;
			final_level_reg <= 17'h0_0000;
		end else begin
			if (first_dec_valid)
				first_level_reg <= abs_sum(first_dec_i, first_dec_q);
			if (gain_out_valid)
				final_level_reg <= abs_sum(gain_out_i, gain_out_q);
		end
	end

	// reference target below clip
	always @* begin
		case (reference_level_select)
			3'h1: ref_frac = `REF_3DB;
			3'h2: ref_frac = `REF_6DB;
			3'h3: ref_frac = `REF_9DB;
			3'h4: ref_frac = `REF_12DB;
			default: ref_frac = `REF_15DB;
		endcase
		ref_level = {1'b0, ref_frac, 8'h00};
	end

	// loop arithmetic
	always @* begin
		if (digital_gain_enable && (final_level_reg > first_level_reg))
			est_level = final_level_reg;
		else
			est_level = first_level_reg;
		if (est_level > ref_level) begin
			err_mag = est_level - ref_level;
			k_index = {1'b0, attack_rate} + `K_OFFSET;
		end else begin
			err_mag = ref_level - est_level;
			k_index = {1'b0, attack_rate} + `K_OFFSET - {1'b0, decay_ratio};
		end
		// odd codes add roughly root two, even codes a whole doubling
		if (k_index[0])
			err_root = {1'b0, err_mag} + {3'b000, err_mag[16:2]} + {4'b0000, err_mag[16:3]}
				+ {6'b00_0000, err_mag[16:5]};
		else
			err_root = {1'b0, err_mag};
		err_shift = {15'h0000, err_root} << k_index[4:1];
		step      = {2'b00, err_shift[32:`STEP_SHIFT]};
		reset_add = reset_seen_reg ? (`RESET_STEP_BASE << reset_weight) : 16'h0000;
		up_sum    = {2'b00, atten_code} + {2'b00, step} + {2'b00, reset_add};
		gain_next = gain_setting_reg;
		if (est_level > ref_level || reset_seen_reg) begin
			if (up_sum > {2'b00, atten_max})
				gain_next[`FIELD_GAIN_CODE] = atten_max[14:0];
			else
				gain_next[`FIELD_GAIN_CODE] = up_sum[14:0];
		end else if (step > atten_code)
			gain_next[`FIELD_GAIN_CODE] = 15'h0000;
		else
			gain_next[`FIELD_GAIN_CODE] = atten_code[14:0] - step[14:0];
	end

	// register writes; a host write wins over a loop update in the same cycle
	always @(posedge core_clk) begin
		if (rst) begin
			gain_setting_reg <= `GAIN_RESET;
			loop_rate_reg    <= `RATE_RESET;
			loop_config_reg  <= `CONFIG_RESET;
		end else begin
			if (reg_write && reg_addr == `ADDR_GAIN_HIGH)
				gain_setting_reg[`FIELD_GAIN_HIGH] <= reg_wdata;
			else if (reg_write && reg_addr == `ADDR_GAIN_LOW)
				gain_setting_reg[`FIELD_GAIN_LOW] <= reg_wdata;
			else if (auto_mode && tick)
				gain_setting_reg <= gain_next;
			if (reg_write && reg_addr == `ADDR_LOOP_RATE)
				loop_rate_reg <= reg_wdata;
			if (reg_write && reg_addr == `ADDR_LOOP_CONFIG)
				loop_config_reg <= reg_wdata;
		end
	end

	// register reads, answered one cycle after the strobe
	always @(posedge core_clk) begin
		if (rst)
			reg_rdata <= `READ_IDLE;
		else if (reg_read) begin
			case (reg_addr)
				`ADDR_GAIN_HIGH:   reg_rdata <= gain_setting_reg[`FIELD_GAIN_HIGH];
				`ADDR_GAIN_LOW:    reg_rdata <= gain_setting_reg[`FIELD_GAIN_LOW];
				`ADDR_LOOP_RATE:   reg_rdata <= loop_rate_reg;
				`ADDR_LOOP_CONFIG: reg_rdata <= loop_config_reg;
				default:           reg_rdata <= `READ_IDLE;
			endcase
		end
	end

	// split the code into analog attenuation and digital gain
	always @* begin
		if (!digital_gain_enable) begin
			analog_code    = atten_code[`FIELD_ANALOG_CODE];
			digital_amount = 14'h0000;
		end else if (atten_code >= `DIG_SPLIT) begin
			analog_code    = atten_code[`FIELD_ANALOG_CODE];
			digital_amount = 14'h0000;
		end else begin
			analog_code    = 14'h0000;
			digital_amount = ~atten_code[`FIELD_ANALOG_CODE];
		end
		// linear factor 1..4 with 14 fraction bits; not exact dB steps
		digital_factor = `UNITY_GAIN + {2'b00, digital_amount} + {1'b0, digital_amount, 1'b0};
	end

	digital_gain_stage #(
		.IN_W  (24),
		.OUT_W (16)
	) u_digital_gain (
		.core_clk    (core_clk),
		.rst         (rst),
		.enable      (digital_gain_enable),
		.gain_factor (digital_factor),
		.in_valid    (last_dec_valid),
		.in_i        (last_dec_i),
		.in_q        (last_dec_q),
		.out_valid   (gain_out_valid),
		.out_i       (gain_out_i),
		.out_q       (gain_out_q)
	);

	// analog controls
	always @(posedge core_clk) begin
		if (rst) begin
			gain_dac_code      <= 8'h00;
			dac_fast_mode      <= 1'b0;
			mixer_atten_enable <= 1'b0;
		end else begin
			gain_dac_code      <= analog_code[`FIELD_DAC_BITS] - 8'h00;
			dac_fast_mode      <= loop_config_reg[`BIT_FAST_ACQ] & auto_mode;
			mixer_atten_enable <= gain_setting_reg[`BIT_MIXER_ATTEN];
		end
	end

	// strength and attenuation fields
	always @* begin
		strength_prod = first_level_reg * `STRENGTH_FULL;
	end

	always @(posedge core_clk) begin
		if (rst) begin
			signal_strength_value <= 6'h00;
			attenuation_report    <= 8'h00;
		end else begin
			if (tick) begin
				if (strength_prod[24:`STRENGTH_SHIFT] > {3'b000, `STRENGTH_MAX})
					signal_strength_value <= `STRENGTH_MAX;
				else
					signal_strength_value <= strength_prod[21:`STRENGTH_SHIFT];
			end
			attenuation_report <= gain_setting_reg[`FIELD_GAIN_HIGH];
		end
	end

	// ADC reset events push attenuation at the next loop update
	always @(posedge core_clk) begin
		if (rst)
			reset_seen_reg <= 1'b0;
		else if (adc_reset_event)
			reset_seen_reg <= 1'b1; // set wins over the tick clear
		else if (tick)
			reset_seen_reg <= 1'b0;
	end

	// event counts per output sample; counters saturate rather than wrap
	always @(posedge core_clk) begin
		if (rst) begin
			overload_run_reg <= {COUNT_W{1'b0}};
			reset_run_reg    <= {COUNT_W{1'b0}};
			overload_count   <= {COUNT_W{1'b0}};
			reset_count      <= {COUNT_W{1'b0}};
		end else if (frame_sample_strobe) begin
			overload_count   <= overload_run_reg;
			reset_count      <= reset_run_reg;
			overload_run_reg <= {{(COUNT_W-1){1'b0}}, adc_overload};
			reset_run_reg    <= {{(COUNT_W-1){1'b0}}, adc_reset_event};
		end else begin
			if (adc_overload && overload_run_reg != {COUNT_W{1'b1}})
				overload_run_reg <= overload_run_reg + {{(COUNT_W-1){1'b0}}, 1'b1};
			if (adc_reset_event && reset_run_reg != {COUNT_W{1'b1}})
				reset_run_reg <= reset_run_reg + {{(COUNT_W-1){1'b0}}, 1'b1};
		end
	end

endmodule // automatic_gain_control_loop

// ---- digital_gain_stage.v ----
`timescale 1ns/10ps
`include "gain_loop_map.vh"

module digital_gain_stage #(
	parameter IN_W  = 24,
	parameter OUT_W = 16
) (
	// clock and reset
	input  wire             core_clk,
	input  wire             rst,
	// control
	input  wire             enable,
	input  wire [15:0]      gain_factor,
	// filter data in
	input  wire             in_valid,
	input  wire [IN_W-1:0]  in_i,
	input  wire [IN_W-1:0]  in_q,
	// scaled data out
	output reg              out_valid,
	output wire [OUT_W-1:0] out_i,
	output wire [OUT_W-1:0] out_q
);

	localparam PW = IN_W + 17;
	localparam SW = PW - `GAIN_FRAC_SHIFT;

	wire [2*IN_W-1:0]  in_bus;
	reg  [2*OUT_W-1:0] out_bus_reg;

	assign in_bus = {in_q, in_i};
	assign out_i  = out_bus_reg[OUT_W-1:0];
	assign out_q  = out_bus_reg[2*OUT_W-1:OUT_W];

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : chan
			wire signed [IN_W-1:0] x;
			wire signed [PW-1:0]   prod;
			wire signed [SW-1:0]   scaled;
			wire                   over;
			reg         [OUT_W-1:0] y;
			assign x      = in_bus[ch*IN_W +: IN_W];
			assign prod   = x * $signed({1'b0, gain_factor});
			assign scaled = prod[PW-1:`GAIN_FRAC_SHIFT];
			// gain up to 4 pushes past the 24-bit range; clip instead of wrapping
			assign over   = (scaled[SW-1:IN_W-1] != {(SW-IN_W+1){scaled[SW-1]}});
			always @* begin
				if (!enable)
					y = x[IN_W-1:IN_W-OUT_W];
				else if (over)
					y = scaled[SW-1] ? {1'b1, {(OUT_W-1){1'b0}}} : {1'b0, {(OUT_W-1){1'b1}}};
				else
					y = scaled[IN_W-1:IN_W-OUT_W];
			end
			always @(posedge core_clk) begin
				if (rst)
					out_bus_reg[ch*OUT_W +: OUT_W] <= {OUT_W{1'b0}};
				else if (in_valid)
					out_bus_reg[ch*OUT_W +: OUT_W] <= y;
			end
		end
	endgenerate

	always @(posedge core_clk) begin
		if (rst)
			out_valid <= 1'b0;
		else
			out_valid <= in_valid;
	end

endmodule // digital_gain_stage

// ---- gain_loop_map.vh ----
`ifndef GAIN_LOOP_MAP_VH
`define GAIN_LOOP_MAP_VH

// register addresses
`define ADDR_GAIN_HIGH      8'h03
`define ADDR_GAIN_LOW       8'h04
`define ADDR_LOOP_RATE      8'h05
`define ADDR_LOOP_CONFIG    8'h06

// field positions
`define BIT_MIXER_ATTEN     15
`define FIELD_GAIN_HIGH     15:8
`define FIELD_GAIN_LOW      7:0
`define FIELD_GAIN_CODE     14:0
`define FIELD_ANALOG_CODE   13:0
`define FIELD_DAC_BITS      13:6
`define BIT_DIG_ENABLE      7
`define FIELD_RESET_WEIGHT  6:4
`define BIT_FAST_ACQ        3
`define FIELD_REF_LEVEL     2:0
`define FIELD_ATTACK        7:4
`define FIELD_DECAY         3:0

// reset values
`define GAIN_RESET          16'h0000
`define RATE_RESET          8'h00
`define CONFIG_RESET        8'h00
`define READ_IDLE           8'h00

// loop timing, in modulator clocks
`define LOOP_PERIOD         60
`define TICK_LAST           6'h3b
`define MANUAL_MIN_GAP      240

// attenuation code space
`define ATTEN_MAX_DIG       16'h7fff
`define ATTEN_MAX_ANA       16'h3fff
`define DIG_SPLIT           16'h4000
`define UNITY_GAIN          16'h4000
`define GAIN_FRAC_SHIFT     14
`define STEP_SHIFT          19
`define K_OFFSET            5'h0f
`define RESET_STEP_BASE     16'h0010

// reference targets as fractions of 256 of full scale
`define REF_OFF             3'h0
`define REF_3DB             8'h90
`define REF_6DB             8'h66
`define REF_9DB             8'h48
`define REF_12DB            8'h33
`define REF_15DB            8'h24

// strength scaling: code 60 at full scale
`define STRENGTH_FULL       8'h3c
`define STRENGTH_SHIFT      16
`define STRENGTH_MAX        6'h3f

`endif

// ---- sample_source.sv ----
`timescale 1ns/10ps
module sample_source (
	// clock and reset
	input  wire        core_clk,
	input  wire        rst,
	// wanted sample values
	input  wire [15:0] lvl_i,
	input  wire [15:0] lvl_q,
	// first decimator stream
	output reg         first_dec_valid,
	output reg  [15:0] first_dec_i,
	output reg  [15:0] first_dec_q
);
	reg [3:0] div_reg;

	// one sample every twelve clocks; between samples the lines carry the inverse,
	// so a design that reads them outside the strobe sees wrong data
	always @(posedge core_clk) begin
		div_reg         <= (rst || div_reg == 4'hb) ? 4'h0 : div_reg + 4'h1;
		first_dec_valid <= !rst && (div_reg == 4'hb);
		first_dec_i     <= (div_reg == 4'hb) ? lvl_i : ~lvl_i;
		first_dec_q     <= (div_reg == 4'hb) ? lvl_q : ~lvl_q;
	end
endmodule // sample_source

// ---- tb.sv ----
`timescale 1ns/10ps
`include "gain_loop_map.vh"
module tb;
	reg         core_clk = 1'b0;
	reg         rst = 1'b1;
	reg  [7:0]  reg_addr = 8'h00;
	reg  [7:0]  reg_wdata = 8'h00;
	reg         reg_write = 1'b0;
	reg         reg_read = 1'b0;
	reg         last_dec_valid = 1'b0;
	reg  [23:0] last_dec_i = 24'h00_0000;
	reg  [23:0] last_dec_q = 24'h00_0000;
	reg         adc_overload = 1'b0;
	reg         adc_reset_event = 1'b0;
	reg         frame_sample_strobe = 1'b0;
	reg  [15:0] lvl_i = 16'h0000;
	reg  [15:0] lvl_q = 16'h0000;
	wire        first_dec_valid, gain_out_valid, dac_fast_mode, mixer_atten_enable;
	wire [15:0] first_dec_i, first_dec_q, gain_out_i, gain_out_q;
	wire [7:0]  reg_rdata, gain_dac_code, attenuation_report;
	wire [5:0]  signal_strength_value;
	wire [3:0]  overload_count, reset_count;
	integer     n_mismatch = 0;
	integer     num_checks = 0;
	integer     k;
	integer     c;

	always #12.5 core_clk = ~core_clk;

	sample_source u_sample_source (
		.core_clk(core_clk), .rst(rst), .lvl_i(lvl_i), .lvl_q(lvl_q),
		.first_dec_valid(first_dec_valid), .first_dec_i(first_dec_i), .first_dec_q(first_dec_q)
	);
	automatic_gain_control_loop #(.COUNT_W(4)) u_automatic_gain_control_loop (
		.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.first_dec_valid(first_dec_valid), .first_dec_i(first_dec_i), .first_dec_q(first_dec_q),
		.last_dec_valid(last_dec_valid), .last_dec_i(last_dec_i), .last_dec_q(last_dec_q),
		.adc_overload(adc_overload), .adc_reset_event(adc_reset_event),
		.frame_sample_strobe(frame_sample_strobe), .gain_out_valid(gain_out_valid),
		.gain_out_i(gain_out_i), .gain_out_q(gain_out_q), .gain_dac_code(gain_dac_code),
		.dac_fast_mode(dac_fast_mode), .mixer_atten_enable(mixer_atten_enable),
		.signal_strength_value(signal_strength_value), .attenuation_report(attenuation_report),
		.overload_count(overload_count), .reset_count(reset_count)
	);

	task chk(input [15:0] got, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask

	task wr(input [7:0] a, input [7:0] d);
		begin
			reg_addr  <= a;
			reg_wdata <= d;
			reg_write <= 1'b1;
			@(posedge core_clk);
			reg_write <= 1'b0;
			@(posedge core_clk);
		end
	endtask

	task rd(input [7:0] a, input [7:0] e);
		begin
			reg_addr <= a;
			reg_read <= 1'b1;
			@(posedge core_clk);
			reg_read <= 1'b0;
			@(posedge core_clk);
			chk({8'h00, reg_rdata}, {8'h00, e});
		end
	endtask

	// both gain bytes count as one rewrite, then the host keeps its distance
	task wg(input [7:0] hi, input [7:0] lo);
		begin
			wr(`ADDR_GAIN_HIGH, hi);
			wr(`ADDR_GAIN_LOW, lo);
			repeat (`MANUAL_MIN_GAP) @(posedge core_clk);
		end
	endtask

	task dp(input [23:0] i, input [23:0] q);
		begin
			repeat (8) @(posedge core_clk);
			last_dec_i     <= i;
			last_dec_q     <= q;
			last_dec_valid <= 1'b1;
			@(posedge core_clk);
			last_dec_valid <= 1'b0;
			last_dec_i     <= ~i;
			last_dec_q     <= ~q;
			// read before this edge's updates land: valid still shows the strobe
			@(posedge core_clk);
			chk({15'h0000, gain_out_valid}, 16'h0001);
		end
	endtask

	task ev(input integer n_ov, input integer n_rs, input [3:0] e_ov, input [3:0] e_rs);
		begin
			for (k = 0; k < 20; k = k + 1) begin
				adc_overload    <= (k < n_ov);
				adc_reset_event <= (k < n_rs);
				@(posedge core_clk);
			end
			adc_overload        <= 1'b0;
			adc_reset_event     <= 1'b0;
			frame_sample_strobe <= 1'b1;
			@(posedge core_clk);
			frame_sample_strobe <= 1'b0;
			@(posedge core_clk);
			chk({12'h000, overload_count, reset_count}, {8'h00, e_ov, e_rs});
		end
	endtask

	task st(input [15:0] i, input [15:0] q, input [5:0] e);
		begin
			lvl_i <= i;
			lvl_q <= q;
			repeat (130) @(posedge core_clk);
			chk({10'h000, signal_strength_value}, {10'h000, e});
		end
	endtask

	task complete_run;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	initial begin
		repeat (50000) @(posedge core_clk);
		n_mismatch = n_mismatch + 1;
		$display("[FAIL] %0t watchdog expired", $time);
		complete_run;
	end

	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (c = 3; c < 7; c = c + 1)
			rd(c[7:0], 8'h00);
		wr(`ADDR_LOOP_RATE, 8'hf0);
		rd(`ADDR_LOOP_RATE, 8'hf0);
		wg(8'hc1, 8'h55);
		rd(`ADDR_GAIN_HIGH, 8'hc1);
		rd(`ADDR_GAIN_LOW, 8'h55);
		chk({8'h00, attenuation_report}, 16'h00c1);
		chk({8'h00, gain_dac_code}, 16'h0005);
		wr(`ADDR_LOOP_CONFIG, 8'h08);
		rd(`ADDR_LOOP_CONFIG, 8'h08);
		wr(8'h07, 8'haa);
		rd(8'h07, 8'h00);
		chk({14'h0000, mixer_atten_enable, dac_fast_mode}, 16'h0002);
		$display("test registers done");
		dp(24'h12_3456, 24'hfe_dcba);
		chk(gain_out_i, 16'h1234);
		chk(gain_out_q, 16'hfedc);
		wg(8'h00, 8'h00);
		wr(`ADDR_LOOP_CONFIG, 8'h80);
		dp(24'h00_0400, 24'h00_0400);
		chk({15'h0000, gain_out_i > 16'h000e && gain_out_i < 16'h0011}, 16'h0001);
		wg(8'h40, 8'h00);
		dp(24'h00_0400, 24'h00_0400);
		chk(gain_out_i, 16'h0004);
		wr(`ADDR_LOOP_CONFIG, 8'h00);
		$display("test data path done");
		ev(3, 2, 4'h3, 4'h2);
		ev(20, 0, 4'hf, 4'h0);
		$display("test event counts done");
		// reference codes 1..5: a large input drives attenuation to its end, a small one back
		for (c = 1; c < 6; c = c + 1) begin
			wr(`ADDR_LOOP_CONFIG, 8'h08 | c[7:0]);
			st(16'h7fff, 16'h7fff, 6'h3b);
			repeat (2400) @(posedge core_clk);
			chk({8'h00, attenuation_report}, 16'h003f);
			chk({8'h00, gain_dac_code}, 16'h00ff);
			chk({15'h0000, dac_fast_mode}, 16'h0001);
			// the estimate ignores attenuation, so both lanes must drop below every target
			lvl_i <= 16'h0010;
			lvl_q <= 16'h0010;
			repeat (2400) @(posedge core_clk);
			chk({8'h00, attenuation_report}, 16'h0000);
		end
		st(16'h4000, 16'h4000, 6'h1e);
		st(16'hc000, 16'h4000, 6'h1e);
		st(16'h0000, 16'h0000, 6'h00);
		$display("test automatic loop done");
		wr(`ADDR_LOOP_CONFIG, 8'h01);
		wr(`ADDR_LOOP_RATE, 8'hff);
		lvl_i <= 16'h7fff;
		lvl_q <= 16'h7fff;
		repeat (2400) @(posedge core_clk);
		lvl_i <= 16'h0010;
		lvl_q <= 16'h0010;
		repeat (600) @(posedge core_clk);
		chk({8'h00, attenuation_report}, 16'h003f);
		$display("test slow decay done");
		// level exactly on the 3 dB target holds the gain; one converter reset pushes it
		wr(`ADDR_LOOP_CONFIG, 8'h71);
		st(16'h4800, 16'h4800, 6'h21);
		wg(8'h10, 8'h00);
		chk({8'h00, attenuation_report}, 16'h0010);
		adc_reset_event <= 1'b1;
		@(posedge core_clk);
		adc_reset_event <= 1'b0;
		repeat (130) @(posedge core_clk);
		chk({8'h00, attenuation_report}, 16'h0018);
		$display("test reset push done");
		complete_run;
	end
endmodule // tb
